// File: dv/pm_event_enable_control_test.sv
// Self-checking bench for the wake enable and sleep control registers.
// Assumes the design checks its own timing relations with inline assertions.
`include "pm_event_cfg.svh"

module pm_event_enable_control_test import pm_event_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 0, reset_n = 0, io_sel = 0, io_wr = 0, io_rd = 0, rd_q = 0;
    logic timer_msb = 0, firmware_event_enable = 0, power_button_input_n = 1;
    logic [7:0] io_addr = 0;
    logic [1:0] io_be = 0;
    logic [15:0] io_wdata = 0, io_rdata;
    pm_flags_t hw_set = '0, sw_clear = '0, flags;
    logic resume_event, control_irq, mgmt_interrupt_out_n, busmaster_reload_event, sleep_start;
    sleep_kind_t sleep_kind_out;
    int error_cnt = 0, compares = 0, cyc = 0, res_n = 0, bm_n = 0;
    logic [15:0] rd_exp[$];
    logic [2:0] kind_exp[$];
    typedef struct {logic [8:0] f; logic [15:0] w; logic [7:0] c; int sci, smi, res, bm;} ev_t;
    // Flag, wake enables, control low byte, then expected SCI, SMI, resume, burst
    ev_t cases[17] = '{'{9'h100, 16'h0400, 8'h00, 0, 0, 1, 0}, '{9'h100, 16'h0000, 8'h00, 0, 0, 0, 0},
        '{9'h080, 16'h0100, 8'h00, 0, 1, -1, 0}, '{9'h080, 16'h0100, 8'h01, 1, 0, -1, 0},
        '{9'h080, 16'h0000, 8'h01, 0, 0, -1, 0}, '{9'h040, 16'h0020, 8'h00, 1, 0, -1, 0},
        '{9'h040, 16'h0000, 8'h00, 0, 0, -1, 0}, '{9'h020, 16'h0001, 8'h00, 1, 0, -1, 0},
        '{9'h020, 16'h0000, 8'h00, 0, 0, -1, 0}, '{9'h010, 16'h0000, 8'h02, 0, 0, -1, 1},
        '{9'h010, 16'h0000, 8'h00, 0, 0, -1, 0}, '{9'h008, 16'h0000, 8'h01, 1, 0, -1, 0},
        '{9'h008, 16'h0000, 8'h00, 0, 0, -1, 0}, '{9'h004, 16'h0000, 8'h01, 1, 0, -1, 0},
        '{9'h004, 16'h0000, 8'h00, 0, 0, -1, 0}, '{9'h002, 16'h0000, 8'h01, 1, 0, -1, 0},
        '{9'h002, 16'h0000, 8'h00, 0, 0, -1, 0}};

    pm_event_enable_control pm_event_enable_control_i (.clk, .reset_n, .io_sel, .io_addr, .io_wr,
        .io_rd, .io_be, .io_wdata, .io_rdata, .hw_set, .sw_clear, .timer_msb,
        .firmware_event_enable, .power_button_input_n, .flags, .resume_event, .control_irq,
        .mgmt_interrupt_out_n, .busmaster_reload_event, .sleep_start, .sleep_kind_out);

    // 50 MHz clock
    always #10 clk = ~clk;

    // Hang guard well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            error_cnt++;
            complete_run();
        end
    end

    // Watcher: pulse counts and oldest-note comparisons
    always @(posedge clk) begin
        if (resume_event === 1'b1) res_n++;
        if (busmaster_reload_event === 1'b1) bm_n++;
        if (rd_q) check("io_rdata", rd_exp.pop_front(), io_rdata);
        if (sleep_start === 1'b1 && kind_exp.size() == 0) check("sleep_start", 0, 1);
        else if (sleep_start === 1'b1) check("sleep_kind_out", kind_exp.pop_front(), sleep_kind_out);
        rd_q = io_rd & io_sel;
    end

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One I/O write, strobe held for exactly one cycle
    task automatic wr(logic [7:0] a, logic [1:0] be, logic [15:0] d);
        @(posedge clk);
        #2 {io_sel, io_wr, io_addr, io_be, io_wdata} = {2'b11, a, be, d};
        @(posedge clk);
        #2 {io_sel, io_wr} = 2'b00;
    endtask

    // One I/O read; the watcher compares the answer a cycle later
    task automatic rd(logic [7:0] a, logic [15:0] e);
        rd_exp.push_back(e);
        @(posedge clk);
        #2 {io_sel, io_rd, io_addr} = {2'b11, a};
        @(posedge clk);
        #2 {io_sel, io_rd} = 2'b00;
    endtask

    task automatic pulse(pm_flags_t s, pm_flags_t c);
        @(posedge clk);
        #2 hw_set = s;
        sw_clear = c;
        @(posedge clk);
        #2 hw_set = '0;
        sw_clear = '0;
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic complete_run();
        $display("Counts: %0d comparisons, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        int r0, b0;
        logic [15:0] d;
        void'($urandom(32'ha72bd4fe));
        repeat (6) @(posedge clk);
        #2 reset_n = 1;
        check("smi_idle", 1, mgmt_interrupt_out_n);
        rd(`PM_OFF_WAKE, 16'h0000);
        rd(`PM_OFF_CTRL, 16'h0000);
        rd(8'h06, 16'h0000);
        $display("test reset done");
        // Random enables, reserved bits and byte lanes
        for (int i = 0; i < 6; i++) begin
            d = 16'($urandom());
            wr(`PM_OFF_WAKE, 2'b11, d);
            rd(`PM_OFF_WAKE, d & `PM_WAKE_MASK);
            wr(`PM_OFF_WAKE, 2'b01, 16'h0000);
            rd(`PM_OFF_WAKE, d & 16'h0500);
        end
        wr(8'h06, 2'b11, 16'hffff);
        rd(8'h06, 16'h0000);
        wr(`PM_OFF_CTRL, 2'b01, 16'h00ff);
        rd(`PM_OFF_CTRL, 16'h0007);
        $display("test registers done");
        foreach (cases[i]) begin
            wr(`PM_OFF_WAKE, 2'b11, cases[i].w);
            wr(`PM_OFF_CTRL, 2'b01, {8'h00, cases[i].c});
            r0 = res_n;
            b0 = bm_n;
            pulse(cases[i].f, '0);
            tick(3);
            check("flags", cases[i].f, flags);
            check("control_irq", cases[i].sci, control_irq);
            check("smi", cases[i].smi, !mgmt_interrupt_out_n);
            check("burst", cases[i].bm, bm_n - b0);
            if (cases[i].res >= 0) check("resume", cases[i].res, res_n - r0);
            pulse('0, cases[i].f);
            tick(2);
            check("idle", 0, {control_irq, ~mgmt_interrupt_out_n, flags});
        end
        $display("test event gating done");
        pulse(9'h040, 9'h040);
        tick(1);
        check("set_wins", 9'h040, flags);
        pulse('0, 9'h1bf);
        check("zero_clear", 9'h040, flags);
        pulse('0, 9'h040);
        timer_msb = 1;
        tick(3);
        check("timer_rise", 9'h020, flags);
        pulse('0, 9'h020);
        timer_msb = 0;
        tick(3);
        check("timer_fall", 9'h020, flags);
        pulse('0, 9'h020);
        $display("test flags done");
        wr(`PM_OFF_CTRL, 2'b01, 16'h0000);
        firmware_event_enable = 1;
        wr(`PM_OFF_CTRL, 2'b01, 16'h0004);
        tick(2);
        check("fw_smi", 16'h0201, {!mgmt_interrupt_out_n, flags});
        pulse('0, 9'h001);
        firmware_event_enable = 0;
        wr(`PM_OFF_CTRL, 2'b01, 16'h0004);
        wr(`PM_OFF_CTRL, 2'b01, 16'h0000);
        tick(2);
        check("fw_off", 16'h0200, {mgmt_interrupt_out_n, flags});
        $display("test release done");
        r0 = res_n;
        power_button_input_n = 0;
        tick(12);
        check("pin_resume", 1, res_n - r0);
        power_button_input_n = 1;
        tick(8);
        pulse('0, 9'h1ff);
        $display("test button pin done");
        for (int k = 0; k < 8; k++) begin
            if (k < 5) kind_exp.push_back(k[2:0]);
            wr(`PM_OFF_CTRL, 2'b10, {3'b001, k[2:0], 10'h000});
            rd(`PM_OFF_CTRL, {3'b000, k[2:0], 10'h000});
        end
        tick(3);
        check("kinds_left", 0, 16'(kind_exp.size()));
        $display("test sleep kinds done");
        complete_run();
    end
endmodule

// File: pkg/pm_event_cfg.svh
// Offsets, field positions and reset values of the power management
// wake enable and sleep control registers.
// Assumes the I/O base has already been decoded by the enclosing bridge.
//
// Summary of operation
// - Clock alarm flag with its wake enable set raises a resume event.
// - Power button flag with its enable set raises a management or control interrupt.
// - Power button pin assertion always raises a resume event.
// - Global event flag with its enable set raises the control interrupt.
// - Timer wrap flag with its enable set raises the control interrupt.
// - Sleep trigger bit always reads back as zero.
// - Writing one to the sleep trigger starts the selected suspend sequence.
// - Three-bit sleep kind field selects the suspend mode entered.
// - Writing one to firmware release sets the firmware flag when enabled.
// - Busmaster flag with reload enable set raises a burst or break event.
// - Route enable sends cover, overheat, input flags, and the button flag when its enable is set, to control interrupt.
// - Both registers reset to zero; reserved bits do nothing and read zero.
// - Flags set by hardware, the firmware flag also by a release write; cleared by writing one; set wins.
// - Timer wrap flag sets whenever timer bit 23 toggles either way.
`ifndef PM_EVENT_CFG_SVH
`define PM_EVENT_CFG_SVH

// Register offsets from the I/O base
`define PM_OFF_WAKE 8'h02
`define PM_OFF_CTRL 8'h04

// Reset values
`define PM_WAKE_RESET 16'h0000
`define PM_CTRL_RESET 16'h0000

// Wake enable fields
`define PM_WAKE_ALARM 10
`define PM_WAKE_BUTTON 8
`define PM_WAKE_GLOBAL 5
`define PM_WAKE_TIMER 0
`define PM_WAKE_MASK 16'h0521

// Sleep control fields
`define PM_CTRL_TRIGGER 13
`define PM_CTRL_KIND_HI 12
`define PM_CTRL_KIND_LO 10
`define PM_CTRL_RELEASE 2
`define PM_CTRL_RELOAD 1
`define PM_CTRL_ROUTE 0

`endif

// File: pkg/pm_event_pkg.sv
// Types shared by the power management event enable block.
// Assumes nothing beyond a SystemVerilog compiler.
package pm_event_pkg;

    // Sticky event flags, one bit each
    typedef struct packed {
        logic clock_alarm_flag;
        logic power_button_flag;
        logic global_event_flag;
        logic timer_wrap_flag;
        logic busmaster_request_flag;
        logic cover_switch_flag;
        logic overheat_flag;
        logic general_input_flag;
        logic firmware_event_flag;
    } pm_flags_t;

    // Sleep kind codes
    typedef enum logic [2:0] {
        KIND_SOFT_OFF = 3'b000,
        KIND_RAM = 3'b001,
        KIND_ON_LOST = 3'b010,
        KIND_ON_CPU_LOST = 3'b011,
        KIND_ON_KEPT = 3'b100,
        KIND_WORKING = 3'b101,
        KIND_RSVD_6 = 3'b110,
        KIND_RSVD_7 = 3'b111
    } sleep_kind_t;

endpackage

// File: rtl/pm_event_enable_control.sv
// Wake enable and sleep control registers with the event gating they steer.
// Assumes an I/O port already qualified by the base decode (io_sel) and
// same-clock event sources; only the power button pin is asynchronous.
`include "pm_event_cfg.svh"

module pm_event_enable_control (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // I/O register port
    input wire logic io_sel,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [1:0] io_be,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    // Event sources
    input wire pm_event_pkg::pm_flags_t hw_set,
    input wire pm_event_pkg::pm_flags_t sw_clear,
    input wire logic timer_msb,
    input wire logic firmware_event_enable,
    input wire logic power_button_input_n,
    // Event outputs
    output pm_event_pkg::pm_flags_t flags,
    output logic resume_event,
    output logic control_irq,
    output logic mgmt_interrupt_out_n,
    output logic busmaster_reload_event,
    output logic sleep_start,
    output pm_event_pkg::sleep_kind_t sleep_kind_out
);
    import pm_event_pkg::*;

    logic [15:0] wake_enable;
    sleep_kind_t sleep_kind;
    logic firmware_release;
    logic busmaster_reload_enable;
    logic control_irq_route_enable;
    logic wr_wake;
    logic wr_ctrl;
    logic trigger_write;
    logic release_write;
    logic [2:0] button_sync;
    logic button_pressed;
    logic button_pressed_d;
    logic button_press;
    logic timer_msb_d;
    pm_flags_t flags_d;
    pm_flags_t set_now;
    pm_flags_t next_flags;
    logic next_sci;
    logic next_smi;
    logic [2:0] kind_wdata;
    localparam logic [15:0] WAKE_BITS = `PM_WAKE_MASK;

    // Write strobes for the two registers
    assign wr_wake = io_sel && io_wr && (io_addr == `PM_OFF_WAKE);
    assign wr_ctrl = io_sel && io_wr && (io_addr == `PM_OFF_CTRL);
    assign trigger_write = wr_ctrl && io_be[1] && io_wdata[`PM_CTRL_TRIGGER];
    assign release_write = wr_ctrl && io_be[0] && io_wdata[`PM_CTRL_RELEASE];

    // Sleep kind field of the write data, for the checks
    assign kind_wdata = io_wdata[`PM_CTRL_KIND_HI:`PM_CTRL_KIND_LO];

    // Wake enable register, defined bits only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_enable <= `PM_WAKE_RESET;
        end else if (wr_wake) begin
            if (io_be[0]) begin
                wake_enable[7:0] <= io_wdata[7:0] & WAKE_BITS[7:0];
            end
            if (io_be[1]) begin
                wake_enable[15:8] <= io_wdata[15:8] & WAKE_BITS[15:8];
            end
        end
    end

    // Sleep control register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_kind <= KIND_SOFT_OFF;
            firmware_release <= 1'b0;
            busmaster_reload_enable <= 1'b0;
            control_irq_route_enable <= 1'b0;
        end else if (wr_ctrl) begin
            if (io_be[1]) begin
                sleep_kind <= sleep_kind_t'(io_wdata[`PM_CTRL_KIND_HI:`PM_CTRL_KIND_LO]);
            end
            if (io_be[0]) begin
                firmware_release <= io_wdata[`PM_CTRL_RELEASE];
                busmaster_reload_enable <= io_wdata[`PM_CTRL_RELOAD];
                control_irq_route_enable <= io_wdata[`PM_CTRL_ROUTE];
            end
        end
    end

    // Sleep sequencing request; working and reserved kinds start nothing but still load sleep_kind_out
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sleep_start <= 1'b0;
            sleep_kind_out <= KIND_SOFT_OFF;
        end else begin
            sleep_start <= trigger_write &&
                (io_wdata[`PM_CTRL_KIND_HI:`PM_CTRL_KIND_LO] < KIND_WORKING);
            if (trigger_write) begin
                sleep_kind_out <= sleep_kind_t'(io_wdata[`PM_CTRL_KIND_HI:`PM_CTRL_KIND_LO]);
            end
        end
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            io_rdata <= 16'h0000;
        end else if (io_sel && io_rd && (io_addr == `PM_OFF_WAKE)) begin
            io_rdata <= wake_enable;
        end else if (io_sel && io_rd && (io_addr == `PM_OFF_CTRL)) begin
            // Trigger bit position always reads zero
            io_rdata <= {2'b00, 1'b0, sleep_kind, 7'h00, firmware_release,
                busmaster_reload_enable, control_irq_route_enable};
        end else begin
            io_rdata <= 16'h0000;
        end
    end

    // Power button pin synchroniser
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            button_sync <= 3'b111;
        end else begin
            button_sync <= {button_sync[1:0], power_button_input_n};
        end
    end

    // Accept a pin change once the last two stages agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            button_pressed <= 1'b0;
        end else if (button_sync[1] == button_sync[2]) begin
            button_pressed <= !button_sync[2];
        end
    end

    // Edge history for presses, timer and flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            button_pressed_d <= 1'b0;
            timer_msb_d <= 1'b0;
            flags_d <= '0;
        end else begin
            button_pressed_d <= button_pressed;
            timer_msb_d <= timer_msb;
            flags_d <= flags;
        end
    end

    assign button_press = button_pressed && !button_pressed_d;

    // Hardware set terms for every flag
    always_comb begin
        set_now = hw_set;
        set_now.power_button_flag = hw_set.power_button_flag || button_press;
        set_now.timer_wrap_flag = hw_set.timer_wrap_flag ||
            (timer_msb != timer_msb_d);
        set_now.firmware_event_flag = hw_set.firmware_event_flag ||
            (release_write && firmware_event_enable);
    end

    // Sticky flags: write-one clear, set beats clear
    assign next_flags = set_now | (flags & ~sw_clear);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // Control and management interrupt levels
    always_comb begin
        next_sci = (flags.global_event_flag && wake_enable[`PM_WAKE_GLOBAL]) ||
            (flags.timer_wrap_flag && wake_enable[`PM_WAKE_TIMER]) ||
            (control_irq_route_enable && (flags.cover_switch_flag ||
            flags.overheat_flag ||
            flags.general_input_flag));
        // Power button needs its own enable before the route choice applies
        if (flags.power_button_flag && wake_enable[`PM_WAKE_BUTTON] &&
            control_irq_route_enable) begin
            next_sci = 1'b1;
        end
        next_smi = (flags.firmware_event_flag && firmware_event_enable) ||
            (flags.power_button_flag && wake_enable[`PM_WAKE_BUTTON] &&
            !control_irq_route_enable);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_irq <= 1'b0;
            mgmt_interrupt_out_n <= 1'b1;
        end else begin
            control_irq <= next_sci;
            mgmt_interrupt_out_n <= !next_smi;
        end
    end

    // Resume and busmaster reload pulses on flag rise; resume also on a button press
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resume_event <= 1'b0;
            busmaster_reload_event <= 1'b0;
        end else begin
            resume_event <= (flags.clock_alarm_flag && !flags_d.clock_alarm_flag &&
                wake_enable[`PM_WAKE_ALARM]) || button_press;
            busmaster_reload_event <= flags.busmaster_request_flag &&
                !flags_d.busmaster_request_flag && busmaster_reload_enable;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_alarm_rise;
        !flags.clock_alarm_flag ##1 flags.clock_alarm_flag && wake_enable[`PM_WAKE_ALARM];
    endsequence

    sequence s_trigger_write;
        trigger_write && (kind_wdata < KIND_WORKING);
    endsequence

    // Synchronised pin moves from released to pressed
    sequence s_pin_press;
        !button_pressed ##1 button_pressed;
    endsequence

    // Wake and interrupt gating
    a_alarm_resume: assert property (s_alarm_rise |=> resume_event)
        else $error("enabled clock alarm gave no resume");
    a_alarm_masked: assert property (!wake_enable[`PM_WAKE_ALARM] &&
        !button_press |=> !resume_event)
        else $error("masked clock alarm gave resume");
    a_button_smi: assert property (flags.power_button_flag &&
        wake_enable[`PM_WAKE_BUTTON] |=> !mgmt_interrupt_out_n || control_irq)
        else $error("enabled power button raised no interrupt");
    a_smi_masked: assert property (!wake_enable[`PM_WAKE_BUTTON] &&
        !(flags.firmware_event_flag && firmware_event_enable) |=> mgmt_interrupt_out_n)
        else $error("management interrupt without an enabled source");
    a_button_resume: assert property (button_press |=> resume_event)
        else $error("button press gave no resume");
    a_pin_press: assert property (s_pin_press |=> resume_event &&
        flags.power_button_flag)
        else $error("pin press gave no resume or flag");
    a_global_sci: assert property (flags.global_event_flag &&
        wake_enable[`PM_WAKE_GLOBAL] |=> control_irq)
        else $error("global flag gave no control interrupt");
    a_timer_sci: assert property (flags.timer_wrap_flag &&
        wake_enable[`PM_WAKE_TIMER] |=> control_irq)
        else $error("timer wrap gave no control interrupt");
    a_sci_masked: assert property ((wake_enable & WAKE_BITS) == 16'h0000 &&
        !control_irq_route_enable |=> !control_irq)
        else $error("control interrupt with every source masked");

    // Register behaviour
    a_trigger_reads: assert property (io_sel && io_rd &&
        io_addr == `PM_OFF_CTRL |=> !io_rdata[`PM_CTRL_TRIGGER])
        else $error("trigger bit read back as one");
    a_sleep_start: assert property (s_trigger_write |=> sleep_start ##1 !sleep_start)
        else $error("sleep trigger did not give one start pulse");
    a_rest_sleep: assert property (trigger_write &&
        kind_wdata >= KIND_WORKING |=> !sleep_start)
        else $error("working or reserved kind started a sleep");
    a_kind_stored: assert property (wr_ctrl && io_be[1] |=>
        sleep_kind == $past(kind_wdata))
        else $error("sleep kind field not stored");
    a_unmapped_read: assert property (io_sel && io_rd && io_addr != `PM_OFF_WAKE &&
        io_addr != `PM_OFF_CTRL |=> io_rdata == 16'h0000)
        else $error("unmapped offset read nonzero");
    a_wake_reserved: assert property (io_sel && io_rd &&
        io_addr == `PM_OFF_WAKE |=> (io_rdata & ~WAKE_BITS) == 16'h0000)
        else $error("reserved wake enable bit read as one");

    // Flags and their events
    a_release_flag: assert property (release_write && firmware_event_enable
        |=> flags.firmware_event_flag ##1 !mgmt_interrupt_out_n)
        else $error("release did not set firmware flag and interrupt");
    a_reload_event: assert property ($rose(flags.busmaster_request_flag) &&
        busmaster_reload_enable |=> busmaster_reload_event)
        else $error("busmaster rise gave no reload event");
    a_reload_masked: assert property (!busmaster_reload_enable |=>
        !busmaster_reload_event)
        else $error("masked busmaster gave reload event");
    a_route_sci: assert property (control_irq_route_enable &&
        flags.overheat_flag |=> control_irq)
        else $error("routed overheat flag gave no control interrupt");
    a_set_wins: assert property (set_now.cover_switch_flag |=> flags.cover_switch_flag)
        else $error("flag set was lost");
    a_flag_clear: assert property (sw_clear.cover_switch_flag &&
        !set_now.cover_switch_flag |=> !flags.cover_switch_flag)
        else $error("write one clear left flag set");
    a_timer_toggle: assert property ($changed(timer_msb) |=> flags.timer_wrap_flag)
        else $error("timer toggle did not set wrap flag");

endmodule
